/* File: shared/borc_pkg.sv */
// Purpose: Constants and types shared by the breaker output relay control block.
// Assumes: 125 MHz system clock; all timers count a common 1 ms tick.
// Notes: Setting widths cover the full documented ranges.
package borc_pkg;

    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICK_W = 17;

    // Timer widths in 1 ms ticks.
    localparam int unsigned TMR_W = 24;
    localparam int unsigned AUX_N = 5;

    // Fallback and no-contact release times, in milliseconds.
    localparam int unsigned BKR_OP_DEFAULT_MS = 2000;
    localparam int unsigned TRIP_NOAUX_MS = 100;
    localparam int unsigned CLOSE_NOAUX_MS = 200;

    // Seal-in setting: 0.00 to 9.99 s in 10 ms steps.
    localparam int unsigned SEAL_W = 10;
    localparam int unsigned SEAL_STEP_MS = 10;
    localparam int unsigned SEAL_MAX = 999;
    localparam logic [SEAL_W-1:0] SEAL_RESET = 10'h004;

    // Dwell setting: 0.1 to 6000.0 s in 100 ms steps.
    localparam int unsigned DWELL_W = 16;
    localparam int unsigned DWELL_STEP_MS = 100;
    localparam int unsigned DWELL_MIN = 1;
    localparam int unsigned DWELL_MAX = 60000;

    // Output type encoding of each auxiliary output.
    localparam logic [1:0] AUX_SELF_RESET = 2'h0;
    localparam logic [1:0] AUX_LATCHED = 2'h1;
    localparam logic [1:0] AUX_PULSED = 2'h2;

    typedef enum logic [1:0] {
        BRK_IDLE,
        BRK_HOLD,
        BRK_SEAL
    } borc_brk_state_t;

endpackage : borc_pkg

/* File: hdl/borc_aux_out.sv */
// Purpose: One configurable auxiliary output: latched, self-resetting or pulsed.
// Assumes: Requests and reset are already synchronous to clk.
// Notes: Drive level follows the configured operated polarity.
`timescale 1ns/1ns
module borc_aux_out (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic request,
    input wire logic reset_cmd,
    input wire logic [1:0] out_type,
    input wire logic operated_energized,
    input wire logic [borc_pkg::DWELL_W-1:0] dwell,
    output logic operated,
    output logic drive
);

    logic op_q;
    logic req_q;
    logic [borc_pkg::TMR_W-1:0] dwell_cnt_q;
    logic [borc_pkg::DWELL_W-1:0] dwell_lim;
    logic [borc_pkg::TMR_W-1:0] dwell_ms;

    // Out-of-range dwell settings are clamped rather than refused.
    always_comb begin
        if (dwell < borc_pkg::DWELL_W'(borc_pkg::DWELL_MIN)) begin
            dwell_lim = borc_pkg::DWELL_W'(borc_pkg::DWELL_MIN);
        end else if (dwell > borc_pkg::DWELL_W'(borc_pkg::DWELL_MAX)) begin
            dwell_lim = borc_pkg::DWELL_W'(borc_pkg::DWELL_MAX);
        end else begin
            dwell_lim = dwell;
        end
        dwell_ms = borc_pkg::TMR_W'(dwell_lim * 24'(borc_pkg::DWELL_STEP_MS));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 1'b0;
        end else if (clk_en) begin
            req_q <= request;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= 1'b0;
            dwell_cnt_q <= '0;
        end else if (clk_en) begin
            case (out_type)
                borc_pkg::AUX_LATCHED: begin
                    // A request beats a reset in the same cycle.
                    if (request) begin
                        op_q <= 1'b1;
                    end else if (reset_cmd) begin
                        op_q <= 1'b0;
                    end
                end
                borc_pkg::AUX_PULSED: begin
                    if (!op_q && request && !req_q) begin
                        op_q <= 1'b1;
                        dwell_cnt_q <= '0;
                    end else if (op_q && tick) begin
                        if (dwell_cnt_q + 24'h000001 >= dwell_ms) begin
                            op_q <= 1'b0;
                        end
                        dwell_cnt_q <= dwell_cnt_q + 24'h000001;
                    end
                end
                default: begin
                    op_q <= request;
                end
            endcase
        end
    end

    assign operated = op_q;
    assign drive = op_q ~^ operated_energized;

endmodule : borc_aux_out

/* File: hdl/borc_top.sv */
// Purpose: Trip, close and five auxiliary output relay drivers of a protection relay.
// Assumes: Feature requests come from logic on clk; contacts and resets come from pins.
// Notes: Every timer counts the common 1 ms tick; all outputs are registered.
`timescale 1ns/1ns

// How it works
// - Trip or close holds until contact confirms new breaker state and request clears.
// - Without a breaker change, release after breaker-operation delay, default 2 seconds.
// - No contacts assigned: trip drops after breaker-failure delay or 100 ms.
// - No contacts assigned: close is held for a fixed 200 ms.
// - Seal-in time is added to the trip and close outputs' reset time.
// - Seal-in settings reset to 40 ms.
// - Seal-in spans 0.00 to 9.99 s in 10 ms steps.
// - Open contact assigned: trip holds until it reports breaker open.
// - Only closed contact assigned: trip holds until it reports breaker open.
// - Closed contact assigned: close holds until it reports breaker closed.
// - Only open contact assigned: close holds until it reports breaker closed.
// - Each auxiliary output has selectable energized or de-energized operated level.
// - Latched auxiliary holds until a key, input or communications reset.
// - Self-resetting auxiliary follows the OR of its requests.
// - Pulsed auxiliary operates for the dwell time from the first request.
// - Each of the five auxiliary outputs has its own independent configuration set.
// - Dwell spans 0.1 to 6000.0 s in 0.1 s steps.
module borc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic trip_request,
    input wire logic close_request,
    input wire logic breaker_closed_contact,
    input wire logic breaker_open_contact,
    input wire logic closed_contact_assigned,
    input wire logic open_contact_assigned,
    input wire logic bkr_op_delay_en,
    input wire logic [borc_pkg::TMR_W-1:0] bkr_op_delay_ms,
    input wire logic bkr_fail_en,
    input wire logic [borc_pkg::TMR_W-1:0] bkr_fail_delay_ms,
    input wire logic seal_load,
    input wire logic [borc_pkg::SEAL_W-1:0] trip_reset_extension_in,
    input wire logic [borc_pkg::SEAL_W-1:0] close_reset_extension_in,
    input wire logic reset_key,
    input wire logic reset_input,
    input wire logic reset_comm,
    input wire logic [borc_pkg::AUX_N-1:0] aux_request,
    input wire logic [2*borc_pkg::AUX_N-1:0] aux_type,
    input wire logic [borc_pkg::AUX_N-1:0] aux_operated_energized,
    input wire logic [borc_pkg::DWELL_W*borc_pkg::AUX_N-1:0] aux_dwell,
    output logic trip_drive,
    output logic close_drive,
    output logic [borc_pkg::AUX_N-1:0] aux_drive,
    output logic [borc_pkg::AUX_N-1:0] aux_operated,
    output logic [borc_pkg::SEAL_W-1:0] trip_reset_extension,
    output logic [borc_pkg::SEAL_W-1:0] close_reset_extension
);

    // Pin synchronisers: three stages, second and third must agree.
    localparam int unsigned PIN_N = 5;
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1_q;
    logic [PIN_N-1:0] pin_s2_q;
    logic [PIN_N-1:0] pin_s3_q;
    logic [PIN_N-1:0] pin_q;

    assign pin_raw = {reset_comm, reset_input, reset_key, breaker_open_contact, breaker_closed_contact};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_q <= '0;
        end else if (clk_en) begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int i = 0; i < PIN_N; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_q[i] <= pin_s3_q[i];
                end
            end
        end
    end

    logic bkr_closed;
    logic bkr_open;
    logic any_reset;
    assign bkr_closed = pin_q[0];
    assign bkr_open = pin_q[1];
    assign any_reset = |pin_q[4:2];

    // Common 1 ms tick.
    logic [borc_pkg::TICK_W-1:0] tick_cnt_q;
    logic tick_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            if (tick_cnt_q == borc_pkg::TICK_W'(borc_pkg::TICK_CYCLES - 1)) begin
                tick_cnt_q <= '0;
                tick_q <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 17'h00001;
                tick_q <= 1'b0;
            end
        end
    end

    // Seal-in settings, loaded on seal_load and clamped.
    logic [borc_pkg::SEAL_W-1:0] trip_seal_q;
    logic [borc_pkg::SEAL_W-1:0] close_seal_q;

    function automatic logic [borc_pkg::SEAL_W-1:0] clamp_seal(input logic [borc_pkg::SEAL_W-1:0] v);
        clamp_seal = (v > borc_pkg::SEAL_W'(borc_pkg::SEAL_MAX)) ? borc_pkg::SEAL_W'(borc_pkg::SEAL_MAX) : v;
    endfunction : clamp_seal

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_seal_q <= borc_pkg::SEAL_RESET;
            close_seal_q <= borc_pkg::SEAL_RESET;
        end else if (clk_en && seal_load) begin
            trip_seal_q <= clamp_seal(trip_reset_extension_in);
            close_seal_q <= clamp_seal(close_reset_extension_in);
        end
    end

    logic [borc_pkg::TMR_W-1:0] trip_seal_ms;
    logic [borc_pkg::TMR_W-1:0] close_seal_ms;
    assign trip_seal_ms = borc_pkg::TMR_W'(trip_seal_q * 24'(borc_pkg::SEAL_STEP_MS));
    assign close_seal_ms = borc_pkg::TMR_W'(close_seal_q * 24'(borc_pkg::SEAL_STEP_MS));

    logic any_contact;
    logic [borc_pkg::TMR_W-1:0] fallback_ms;
    logic [borc_pkg::TMR_W-1:0] trip_noaux_ms;
    logic trip_confirmed;
    logic close_confirmed;
    assign any_contact = closed_contact_assigned | open_contact_assigned;
    assign fallback_ms = bkr_op_delay_en ? bkr_op_delay_ms : borc_pkg::TMR_W'(borc_pkg::BKR_OP_DEFAULT_MS);
    assign trip_noaux_ms = bkr_fail_en ? bkr_fail_delay_ms : borc_pkg::TMR_W'(borc_pkg::TRIP_NOAUX_MS);

    // The open contact has priority for trip; the closed contact stands in inverted.
    always_comb begin
        if (open_contact_assigned) begin
            trip_confirmed = bkr_open;
        end else begin
            trip_confirmed = !bkr_closed;
        end
        if (closed_contact_assigned) begin
            close_confirmed = bkr_closed;
        end else begin
            close_confirmed = !bkr_open;
        end
    end

    // Trip channel.
    borc_pkg::borc_brk_state_t trip_st_q;
    logic [borc_pkg::TMR_W-1:0] trip_tmr_q;
    logic trip_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_st_q <= borc_pkg::BRK_IDLE;
            trip_tmr_q <= '0;
            trip_q <= 1'b0;
        end else if (clk_en) begin
            case (trip_st_q)
                borc_pkg::BRK_IDLE: begin
                    trip_tmr_q <= '0;
                    if (trip_request) begin
                        trip_st_q <= borc_pkg::BRK_HOLD;
                        trip_q <= 1'b1;
                    end
                end
                borc_pkg::BRK_HOLD: begin
                    // The release timer runs only while the request is absent.
                    if (trip_request) begin
                        trip_tmr_q <= '0;
                    end else if (any_contact && trip_confirmed) begin
                        trip_st_q <= borc_pkg::BRK_SEAL;
                        trip_tmr_q <= '0;
                    end else if (tick_q) begin
                        trip_tmr_q <= trip_tmr_q + 24'h000001;
                        if (trip_tmr_q + 24'h000001 >= (any_contact ? fallback_ms : trip_noaux_ms)) begin
                            trip_st_q <= borc_pkg::BRK_SEAL;
                            trip_tmr_q <= '0;
                        end
                    end
                end
                borc_pkg::BRK_SEAL: begin
                    if (trip_tmr_q >= trip_seal_ms) begin
                        trip_st_q <= borc_pkg::BRK_IDLE;
                        trip_q <= 1'b0;
                    end else if (tick_q) begin
                        trip_tmr_q <= trip_tmr_q + 24'h000001;
                    end
                end
                default: begin
                    trip_st_q <= borc_pkg::BRK_IDLE;
                    trip_q <= 1'b0;
                end
            endcase
        end
    end

    // Close channel.
    borc_pkg::borc_brk_state_t close_st_q;
    logic [borc_pkg::TMR_W-1:0] close_tmr_q;
    logic close_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            close_st_q <= borc_pkg::BRK_IDLE;
            close_tmr_q <= '0;
            close_q <= 1'b0;
        end else if (clk_en) begin
            case (close_st_q)
                borc_pkg::BRK_IDLE: begin
                    close_tmr_q <= '0;
                    if (close_request) begin
                        close_st_q <= borc_pkg::BRK_HOLD;
                        close_q <= 1'b1;
                    end
                end
                borc_pkg::BRK_HOLD: begin
                    if (!any_contact) begin
                        // Fixed operated time regardless of the request.
                        if (tick_q) begin
                            close_tmr_q <= close_tmr_q + 24'h000001;
                            if (close_tmr_q + 24'h000001 >= borc_pkg::TMR_W'(borc_pkg::CLOSE_NOAUX_MS)) begin
                                close_st_q <= borc_pkg::BRK_SEAL;
                                close_tmr_q <= '0;
                            end
                        end
                    end else if (close_request) begin
                        close_tmr_q <= '0;
                    end else if (close_confirmed) begin
                        close_st_q <= borc_pkg::BRK_SEAL;
                        close_tmr_q <= '0;
                    end else if (tick_q) begin
                        close_tmr_q <= close_tmr_q + 24'h000001;
                        if (close_tmr_q + 24'h000001 >= fallback_ms) begin
                            close_st_q <= borc_pkg::BRK_SEAL;
                            close_tmr_q <= '0;
                        end
                    end
                end
                borc_pkg::BRK_SEAL: begin
                    if (close_tmr_q >= close_seal_ms) begin
                        close_st_q <= borc_pkg::BRK_IDLE;
                        close_q <= 1'b0;
                    end else if (tick_q) begin
                        close_tmr_q <= close_tmr_q + 24'h000001;
                    end
                end
                default: begin
                    close_st_q <= borc_pkg::BRK_IDLE;
                    close_q <= 1'b0;
                end
            endcase
        end
    end

    // Auxiliary outputs; each gets its own slice of every setting.
    logic [borc_pkg::AUX_N-1:0] aux_op;
    logic [borc_pkg::AUX_N-1:0] aux_lvl;
    logic [borc_pkg::AUX_N-1:0] aux_op_q;
    logic [borc_pkg::AUX_N-1:0] aux_drive_q;

    for (genvar g = 0; g < borc_pkg::AUX_N; g++) begin : g_aux
        borc_aux_out u_aux (
            .clk(clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .tick(tick_q),
            .request(aux_request[g]),
            .reset_cmd(any_reset),
            .out_type(aux_type[2*g +: 2]),
            .operated_energized(aux_operated_energized[g]),
            .dwell(aux_dwell[borc_pkg::DWELL_W*g +: borc_pkg::DWELL_W]),
            .operated(aux_op[g]),
            .drive(aux_lvl[g])
        );
    end

    // Registered so every output leaves a flip-flop; in reset every drive
    // reads low, whatever the operated polarity.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_op_q <= '0;
            aux_drive_q <= '0;
        end else if (clk_en) begin
            aux_op_q <= aux_op;
            aux_drive_q <= aux_lvl;
        end
    end

    assign trip_drive = trip_q;
    assign close_drive = close_q;
    assign aux_drive = aux_drive_q;
    assign aux_operated = aux_op_q;
    assign trip_reset_extension = trip_seal_q;
    assign close_reset_extension = close_seal_q;

endmodule : borc_top

/* File: test/borc_top_chk.sv */
// Purpose: Port-level assertions for the breaker output relay control block.
// Assumes: One clock domain; rst_n clears every timer and relay output; seal settings reset to 40 ms.
// Notes: Timer expiry is not asserted; one 1 ms tick outlasts a short run.
`timescale 1ns/1ns
module borc_top_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic trip_request,
    input wire logic close_request,
    input wire logic seal_load,
    input wire logic [borc_pkg::SEAL_W-1:0] trip_reset_extension_in,
    input wire logic [borc_pkg::SEAL_W-1:0] close_reset_extension_in,
    input wire logic reset_key,
    input wire logic reset_input,
    input wire logic reset_comm,
    input wire logic [borc_pkg::AUX_N-1:0] aux_request,
    input wire logic [2*borc_pkg::AUX_N-1:0] aux_type,
    input wire logic [borc_pkg::AUX_N-1:0] aux_operated_energized,
    input wire logic trip_drive,
    input wire logic close_drive,
    input wire logic [borc_pkg::AUX_N-1:0] aux_drive,
    input wire logic [borc_pkg::AUX_N-1:0] aux_operated,
    input wire logic [borc_pkg::SEAL_W-1:0] trip_reset_extension,
    input wire logic [borc_pkg::SEAL_W-1:0] close_reset_extension
);
    localparam logic [borc_pkg::SEAL_W-1:0] SEAL_TOP = 10'h3e7;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_trip_take;
        clk_en && trip_request && !trip_drive;
    endsequence
    sequence s_aux0(logic r);
        clk_en && aux_type[1:0] == borc_pkg::AUX_SELF_RESET && aux_request[0] == r;
    endsequence
    // A synchronised reset may still be in flight, hence six quiet cycles.
    sequence s_latch_quiet;
        clk_en && aux_type[3:2] == borc_pkg::AUX_LATCHED && !reset_key && !reset_input && !reset_comm;
    endsequence
    chk_trip_start: assert property (s_trip_take |=> trip_drive)
        else $error("trip output did not operate on request");
    chk_close_start: assert property (clk_en && close_request && !close_drive |=> close_drive)
        else $error("close output did not operate on request");
    chk_trip_held: assert property (s_trip_take ##1 (clk_en && trip_request)[*8] |-> trip_drive)
        else $error("trip output released while request held");
    chk_trip_seal: assert property (clk_en && seal_load |=> trip_reset_extension ==
        (($past(trip_reset_extension_in) > SEAL_TOP) ? SEAL_TOP : $past(trip_reset_extension_in)))
        else $error("trip seal setting not loaded or clamped");
    chk_close_seal: assert property (clk_en && seal_load |=> close_reset_extension ==
        (($past(close_reset_extension_in) > SEAL_TOP) ? SEAL_TOP : $past(close_reset_extension_in)))
        else $error("close seal setting not loaded or clamped");
    chk_seal_keep: assert property (!(clk_en && seal_load) |=> $stable(trip_reset_extension)
        && $stable(close_reset_extension))
        else $error("seal setting changed without load");
    chk_aux_follow: assert property (s_aux0(1'b1) ##1 s_aux0(1'b1) |=> aux_operated[0])
        else $error("self-resetting output not operated");
    chk_aux_drop: assert property (s_aux0(1'b0) ##1 s_aux0(1'b0) |=> !aux_operated[0])
        else $error("self-resetting output not released");
    chk_aux_level: assert property ($past(rst_n) && $past(clk_en) && $stable(aux_operated_energized)
        |-> aux_drive == ~(aux_operated ^ aux_operated_energized))
        else $error("auxiliary drive level wrong for polarity");
    chk_latch_keep: assert property (s_latch_quiet[*6] ##0 aux_operated[1] |=> aux_operated[1])
        else $error("latched output released without reset");
endmodule : borc_top_chk

bind borc_top borc_top_chk u_chk (.clk, .rst_n, .clk_en, .trip_request, .close_request, .seal_load,
    .trip_reset_extension_in, .close_reset_extension_in, .reset_key, .reset_input, .reset_comm, .aux_request,
    .aux_type, .aux_operated_energized, .trip_drive, .close_drive, .aux_drive, .aux_operated,
    .trip_reset_extension, .close_reset_extension);

/* File: test/borc_breaker_model.sv */
// Purpose: Circuit breaker with complementary auxiliary contacts, driven by the coil outputs.
// Assumes: The breaker starts closed after reset.
// Notes: hold_state models a stuck mechanism that never answers the coil.
`timescale 1ns/1ns
module borc_breaker_model #(
    parameter int OP_CYCLES = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trip_drive,
    input wire logic close_drive,
    input wire logic hold_state,
    output logic breaker_closed_contact,
    output logic breaker_open_contact
);
    logic closed_q;
    int move_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            closed_q <= 1'b1;
            move_q <= 0;
        end else if (!hold_state && ((trip_drive && closed_q) || (close_drive && !closed_q))) begin
            move_q <= (move_q == OP_CYCLES) ? 0 : move_q + 1;
            closed_q <= (move_q == OP_CYCLES) ? !closed_q : closed_q;
        end else begin
            move_q <= 0;
        end
    end
    assign breaker_closed_contact = closed_q;
    assign breaker_open_contact = !closed_q;
endmodule : borc_breaker_model

/* File: test/borc_top_test.sv */
// Purpose: Self-checking bench for the breaker output relay control block.
// Assumes: Breaker behaviour comes from borc_breaker_model.
// Notes: A tick is 125000 cycles, so timer expiry is left to longer runs.
`timescale 1ns/1ns
module borc_top_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic trip_request = 1'b0;
    logic close_request = 1'b0;
    logic closed_contact_assigned = 1'b0;
    logic open_contact_assigned = 1'b0;
    logic hold_state = 1'b0;
    logic seal_load = 1'b0;
    logic [borc_pkg::SEAL_W-1:0] trip_ext_in = 10'h000;
    logic [borc_pkg::SEAL_W-1:0] close_ext_in = 10'h000;
    logic [2:0] resets = 3'h0;
    logic [borc_pkg::AUX_N-1:0] aux_request = 5'h00;
    logic [2*borc_pkg::AUX_N-1:0] aux_type = 10'h000;
    logic [borc_pkg::AUX_N-1:0] aux_energized = 5'h1f;
    logic [borc_pkg::DWELL_W*borc_pkg::AUX_N-1:0] aux_dwell = {5{16'h0001}};
    logic trip_drive, close_drive, closed_contact, open_contact;
    wire [1:0] drv = {close_drive, trip_drive};
    logic [borc_pkg::AUX_N-1:0] aux_drive, aux_operated;
    logic [borc_pkg::SEAL_W-1:0] trip_ext, close_ext;
    int err_total = 0;
    int tests_run = 0;

    always #4 clk = ~clk;

    borc_top dut (.clk, .rst_n, .clk_en, .trip_request, .close_request, .breaker_closed_contact(closed_contact),
        .breaker_open_contact(open_contact), .closed_contact_assigned, .open_contact_assigned,
        .bkr_op_delay_en(1'b0), .bkr_op_delay_ms(24'h0007d0), .bkr_fail_en(1'b0), .bkr_fail_delay_ms(24'h000064),
        .seal_load, .trip_reset_extension_in(trip_ext_in), .close_reset_extension_in(close_ext_in),
        .reset_key(resets[0]), .reset_input(resets[1]), .reset_comm(resets[2]), .aux_request, .aux_type,
        .aux_operated_energized(aux_energized), .aux_dwell, .trip_drive, .close_drive, .aux_drive, .aux_operated,
        .trip_reset_extension(trip_ext), .close_reset_extension(close_ext));
    borc_breaker_model u_bkr (.clk, .rst_n, .trip_drive, .close_drive, .hold_state,
        .breaker_closed_contact(closed_contact), .breaker_open_contact(open_contact));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic load_seal(input logic [9:0] t, input logic [9:0] c, input logic [15:0] exp);
        @(posedge clk);
        trip_ext_in <= t;
        close_ext_in <= c;
        seal_load <= 1'b1;
        @(posedge clk);
        seal_load <= 1'b0;
        step(1);
        check("trip_ext", 16'(trip_ext), exp);
        check("close_ext", 16'(close_ext), exp);
    endtask : load_seal

    // The breaker starts stuck, so an early release shows before it moves.
    task automatic run_brk(input logic is_close, input logic oa, input logic ca);
        int n;
        @(posedge clk);
        open_contact_assigned <= oa;
        closed_contact_assigned <= ca;
        hold_state <= 1'b1;
        trip_request <= !is_close;
        close_request <= is_close;
        step(10);
        check("brk_on", 16'(drv[is_close]), 16'h1);
        @(posedge clk);
        trip_request <= 1'b0;
        close_request <= 1'b0;
        step(20);
        check("brk_stuck", 16'(drv[is_close]), 16'h1);
        @(posedge clk);
        hold_state <= 1'b0;
        n = 0;
        while (drv[is_close] !== 1'b0 && n < 60) begin
            step(1);
            n++;
        end
        check("brk_off", 16'(drv[is_close]), 16'h0);
        check("brk_moved", 16'(closed_contact), 16'(is_close));
    endtask : run_brk

    task automatic aux_self();
        for (int g = 0; g < borc_pkg::AUX_N; g++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge clk);
                aux_energized[g] <= p[0];
                aux_request[g] <= 1'b1;
                step(3);
                check("aux_on", 16'(aux_operated[g]), 16'h1);
                check("aux_drv_on", 16'(aux_drive[g]), 16'(p[0]));
                @(posedge clk);
                aux_request[g] <= 1'b0;
                step(3);
                check("aux_off", 16'(aux_operated[g]), 16'h0);
                check("aux_drv_off", 16'(aux_drive[g]), 16'(!p[0]));
            end
        end
    endtask : aux_self

    task automatic aux_latch();
        for (int r = 0; r < 3; r++) begin
            @(posedge clk);
            aux_type[3:2] <= borc_pkg::AUX_LATCHED;
            aux_request[1] <= 1'b1;
            @(posedge clk);
            aux_request[1] <= 1'b0;
            step(10);
            check("latch_hold", 16'(aux_operated[1]), 16'h1);
            @(posedge clk);
            resets <= 3'(1 << r);
            repeat (3) @(posedge clk);
            resets <= 3'h0;
            step(8);
            check("latch_clear", 16'(aux_operated[1]), 16'h0);
        end
    endtask : aux_latch

    task automatic aux_pulse();
        @(posedge clk);
        aux_type[5:4] <= borc_pkg::AUX_PULSED;
        aux_request[2] <= 1'b1;
        repeat (3) @(posedge clk);
        clk_en <= 1'b0;
        aux_request[2] <= 1'b0;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
        step(10);
        check("pulse_hold", 16'(aux_operated[2]), 16'h1);
    endtask : aux_pulse

    task automatic mid_reset();
        @(posedge clk);
        trip_request <= 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        #1;
        check("rst_trip", 16'(trip_drive), 16'h0);
        check("rst_aux", 16'(aux_operated), 16'h0);
        check("rst_ext", 16'(trip_ext), 16'h0004);
        @(posedge clk);
        trip_request <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask : mid_reset

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        step(2);
        check("trip_ext_rst", 16'(trip_ext), 16'h0004);
        check("close_ext_rst", 16'(close_ext), 16'h0004);
        load_seal(10'h3ff, 10'h3e8, 16'h03e7);
        load_seal(10'h000, 10'h000, 16'h0000);
        run_brk(1'b0, 1'b1, 1'b1);
        run_brk(1'b1, 1'b1, 1'b1);
        run_brk(1'b0, 1'b0, 1'b1);
        run_brk(1'b1, 1'b1, 1'b0);
        aux_self();
        aux_latch();
        aux_pulse();
        mid_reset();
        step(4);
        give_verdict();
    end

    // The run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        give_verdict();
    end
endmodule : borc_top_test
